// [include/timer_ppg_map.svh]
// register offsets, field positions and reset values of the capture timer
`ifndef TIMER_PPG_MAP_SVH
`define TIMER_PPG_MAP_SVH

`define OFS_TIMER_MODE_CTRL 12'h000
`define OFS_CAPCOMP_CTRL 12'h004
`define OFS_PRESCALER_MODE 12'h008
`define OFS_OUTPUT_CTRL 12'h00C
`define OFS_COMPARE_CAPTURE_A 12'h010
`define OFS_COMPARE_CAPTURE_B 12'h014
`define OFS_UP_COUNTER 12'h018
`define OFS_STATUS 12'h01C

`define BIT_TWO_CAPTURE 0
`define BIT_OUT_ENABLE 0
`define BIT_OUT_INVERT_ON_A 1
`define BIT_OUT_INVERT_ON_B 4
`define BIT_OVERFLOW_FLAG 0
`define POS_CLK_SEL 0
`define POS_EDGE_SEL_A 4
`define POS_EDGE_SEL_B 6

`define RST_MODE 2'h0
`define RST_BYTE 8'h00
`define RST_WORD16 16'h0000
`define COUNT_MAX 16'hFFFF
`define CLK_SEL_TRIGGER 2'h3

`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2

`endif

// [include/timer_ppg_pkg.sv]
// types shared by the capture timer modules
package timer_ppg_pkg;

    typedef enum logic [1:0] {
        MODE_STOP = 2'h0,
        MODE_INTERVAL = 2'h1,
        MODE_PPG = 2'h2,
        MODE_FREE_RUN = 2'h3
    } timer_mode_t;

    typedef enum logic [1:0] {
        EDGE_FALLING = 2'h0,
        EDGE_RISING = 2'h1,
        EDGE_PROHIBITED = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_t;

endpackage

// [rtl/trig_filter.sv]
// double-sample noise filter and valid-edge detector for one trigger pin
`timescale 1ns/1ps
`default_nettype none
module trig_filter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // sampling
    input wire logic sample_en,
    input wire logic pin,
    input wire timer_ppg_pkg::edge_sel_t edge_sel,
    // result
    output logic edge_pulse
);
    logic [1:0] smp_reg;
    logic level_reg;
    logic change;

    // a new level counts only once two consecutive samples agree
    assign change = sample_en && (smp_reg[1] == smp_reg[0])
        && (smp_reg[0] != level_reg);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            smp_reg <= 2'h0;
        end else if (sample_en) begin
            smp_reg <= {smp_reg[0], pin};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            level_reg <= 1'b0;
        end else if (change) begin
            level_reg <= smp_reg[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            edge_pulse <= 1'b0;
        end else begin
            case (edge_sel)
                timer_ppg_pkg::EDGE_FALLING: edge_pulse <= change && !smp_reg[0];
                timer_ppg_pkg::EDGE_RISING: edge_pulse <= change && smp_reg[0];
                timer_ppg_pkg::EDGE_BOTH: edge_pulse <= change;
                default: edge_pulse <= 1'b0;
            endcase
        end
    end
endmodule // trig_filter
`default_nettype wire

// [rtl/timer_ppg_pulse_capture.sv]
// 16-bit timer with interval, pulse generator and pulse-width capture modes
`timescale 1ns/1ps
`default_nettype none
`include "timer_ppg_map.svh"
module timer_ppg_pulse_capture #(
    parameter int DIV_MID_LOG2 = 2,
    parameter int DIV_SLOW_LOG2 = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire timer_ppg_pkg::ahb_req_t ahb_req,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pins
    input wire logic trigger_in_a,
    input wire logic trigger_in_b,
    output logic timer_out,
    // interrupt requests
    output logic match_a_irq,
    output logic match_b_irq
);
    if (DIV_MID_LOG2 < 1 || DIV_SLOW_LOG2 <= DIV_MID_LOG2
        || DIV_SLOW_LOG2 > 16) begin : g_bad_taps
        $error("prescaler tap widths out of range");
    end

    timer_ppg_pkg::timer_mode_t mode_reg;
    logic [7:0] capcomp_ctrl_reg;
    logic [7:0] prescaler_mode_reg;
    logic [7:0] output_ctrl_reg;
    logic [15:0] compare_capture_a_reg;
    logic [15:0] compare_capture_b_reg;
    logic [15:0] up_counter_reg;
    logic overflow_flag_reg;
    logic out_level_reg;
    logic [DIV_SLOW_LOG2-1:0] div_reg;

    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic addr_phase;
    logic wr_en;
    logic [31:0] rd_mux;

    logic [1:0] clk_sel;
    logic tick_div;
    logic tick;
    logic edge_a;
    logic edge_b;
    logic running;
    logic compare_mode;
    logic match_a;
    logic match_b;
    logic cap_b;
    logic cap_a;
    logic ovf_set;

    // ---- bus slave: zero wait states, read data registered in address phase
    assign addr_phase = ahb_req.hsel && ahb_req.hready
        && ahb_req.htrans[`HTRANS_NONSEQ_BIT];
    assign wr_en = wr_pend_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_phase && ahb_req.hwrite
                && (ahb_req.hsize == `HSIZE_WORD);
            wr_addr_reg <= ahb_req.haddr[11:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ahb_req.haddr[11:0])
            `OFS_TIMER_MODE_CTRL: rd_mux = {30'h0, mode_reg};
            `OFS_CAPCOMP_CTRL: rd_mux = {24'h0, capcomp_ctrl_reg};
            `OFS_PRESCALER_MODE: rd_mux = {24'h0, prescaler_mode_reg};
            `OFS_OUTPUT_CTRL: rd_mux = {24'h0, output_ctrl_reg};
            `OFS_COMPARE_CAPTURE_A: rd_mux = {16'h0, compare_capture_a_reg};
            `OFS_COMPARE_CAPTURE_B: rd_mux = {16'h0, compare_capture_b_reg};
            `OFS_UP_COUNTER: rd_mux = {16'h0, up_counter_reg};
            `OFS_STATUS: rd_mux = {31'h0, overflow_flag_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            if (addr_phase && !ahb_req.hwrite) begin
                hrdata <= rd_mux;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_reg <= timer_ppg_pkg::MODE_STOP;
            capcomp_ctrl_reg <= `RST_BYTE;
            prescaler_mode_reg <= `RST_BYTE;
            output_ctrl_reg <= `RST_BYTE;
        end else if (wr_en) begin
            case (wr_addr_reg)
                `OFS_TIMER_MODE_CTRL:
                    mode_reg <= timer_ppg_pkg::timer_mode_t'(ahb_req.hwdata[1:0]);
                `OFS_CAPCOMP_CTRL: capcomp_ctrl_reg <= ahb_req.hwdata[7:0];
                `OFS_PRESCALER_MODE: prescaler_mode_reg <= ahb_req.hwdata[7:0];
                `OFS_OUTPUT_CTRL: output_ctrl_reg <= ahb_req.hwdata[7:0];
                default: ;
            endcase
        end
    end

    // ---- count clock selection
    assign clk_sel = prescaler_mode_reg[`POS_CLK_SEL +: 2];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_comb begin
        case (clk_sel)
            2'h0: tick_div = 1'b1;
            2'h1: tick_div = &div_reg[DIV_MID_LOG2-1:0];
            2'h2: tick_div = &div_reg;
            default: tick_div = 1'b0;
        endcase
    end

    // external count clock: trigger_in_a is filtered at main_clock rate
    assign tick = (clk_sel == `CLK_SEL_TRIGGER) ? edge_a : tick_div;

    trig_filter filt_a (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_en((clk_sel == `CLK_SEL_TRIGGER) || tick_div),
        .pin(trigger_in_a),
        .edge_sel(timer_ppg_pkg::edge_sel_t'(
            prescaler_mode_reg[`POS_EDGE_SEL_A +: 2])),
        .edge_pulse(edge_a)
    );

    trig_filter filt_b (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sample_en(tick),
        .pin(trigger_in_b),
        .edge_sel(timer_ppg_pkg::edge_sel_t'(
            prescaler_mode_reg[`POS_EDGE_SEL_B +: 2])),
        .edge_pulse(edge_b)
    );

    // ---- counter, compare and capture events
    assign running = (mode_reg != timer_ppg_pkg::MODE_STOP);
    assign compare_mode = (mode_reg == timer_ppg_pkg::MODE_INTERVAL)
        || (mode_reg == timer_ppg_pkg::MODE_PPG);
    assign match_a = compare_mode && tick
        && (up_counter_reg == compare_capture_a_reg);
    assign match_b = compare_mode && tick
        && (up_counter_reg == compare_capture_b_reg);
    assign cap_b = (mode_reg == timer_ppg_pkg::MODE_FREE_RUN) && edge_a;
    assign cap_a = (mode_reg == timer_ppg_pkg::MODE_FREE_RUN) && edge_b
        && capcomp_ctrl_reg[`BIT_TWO_CAPTURE];
    // a wrap from FFFFH in free-run mode, or a match on FFFFH, is the only overflow
    assign ovf_set = running && tick && (up_counter_reg == `COUNT_MAX)
        && (!compare_mode || compare_capture_a_reg == `COUNT_MAX);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            up_counter_reg <= `RST_WORD16;
        end else if (!running) begin
            up_counter_reg <= `RST_WORD16;
        end else if (match_a) begin
            up_counter_reg <= `RST_WORD16;
        end else if (tick) begin
            up_counter_reg <= up_counter_reg + 16'h0001;
        end
    end

    // captures win over a software write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            compare_capture_a_reg <= `RST_WORD16;
        end else if (cap_a) begin
            compare_capture_a_reg <= up_counter_reg;
        end else if (wr_en && wr_addr_reg == `OFS_COMPARE_CAPTURE_A) begin
            compare_capture_a_reg <= ahb_req.hwdata[15:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            compare_capture_b_reg <= `RST_WORD16;
        end else if (cap_b) begin
            compare_capture_b_reg <= up_counter_reg;
        end else if (wr_en && wr_addr_reg == `OFS_COMPARE_CAPTURE_B) begin
            compare_capture_b_reg <= ahb_req.hwdata[15:0];
        end
    end

    // software writes one to clear; a new overflow in that cycle wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            overflow_flag_reg <= 1'b0;
        end else if (ovf_set) begin
            overflow_flag_reg <= 1'b1;
        end else if (wr_en && wr_addr_reg == `OFS_STATUS
            && ahb_req.hwdata[`BIT_OVERFLOW_FLAG]) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
        end else begin
            match_a_irq <= match_a || cap_a;
            match_b_irq <= match_b || cap_b;
        end
    end

    // ---- output: high from count 0 through b, low from b+1 through a
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_level_reg <= 1'b1;
        end else if (mode_reg != timer_ppg_pkg::MODE_PPG) begin
            out_level_reg <= 1'b1;
        end else if (match_a && output_ctrl_reg[`BIT_OUT_INVERT_ON_A]) begin
            out_level_reg <= !out_level_reg;
        end else if (match_b && output_ctrl_reg[`BIT_OUT_INVERT_ON_B]) begin
            out_level_reg <= !out_level_reg;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= output_ctrl_reg[`BIT_OUT_ENABLE]
                && (mode_reg == timer_ppg_pkg::MODE_PPG)
                && out_level_reg;
        end
    end
endmodule // timer_ppg_pulse_capture
`default_nettype wire

// [test/timer_ppg_props.sv]
// port assertions for the capture timer
`timescale 1ns/1ps
`default_nettype none
module timer_ppg_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // bus
    input wire timer_ppg_pkg::ahb_req_t ahb_req,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // pins and requests
    input wire logic trigger_in_a,
    input wire logic trigger_in_b,
    input wire logic timer_out,
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    logic wr_q;
    logic [11:0] adr_q;
    logic [1:0] mode_q;
    logic fr;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // shadow of the mode register, taken from bus writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            adr_q <= 12'h000;
            mode_q <= 2'h0;
        end else begin
            wr_q <= ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1]
                & ahb_req.hwrite & (ahb_req.hsize == 3'h2);
            adr_q <= ahb_req.haddr[11:0];
            if (wr_q && adr_q == 12'h000) begin
                mode_q <= ahb_req.hwdata[1:0];
            end
        end
    end
    assign fr = (mode_q == timer_ppg_pkg::MODE_FREE_RUN);
    // quiet pin, then a pulse one cycle wide
    sequence glitch_a;
        (fr && $stable(trigger_in_a))[*6] ##1 $changed(trigger_in_a)
            ##1 $changed(trigger_in_a);
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_IRQ_A_PULSE: assert property (match_a_irq |=> !match_a_irq)
        else $error("match a request longer than one cycle");
    AST_IRQ_B_PULSE: assert property (match_b_irq |-> !$past(match_b_irq))
        else $error("match b request longer than one cycle");
    AST_OUT_IDLE: assert property (
        (mode_q != timer_ppg_pkg::MODE_PPG)[*3] |-> !timer_out)
        else $error("timer output high outside pulse mode");
    AST_STOP_QUIET: assert property (
        (mode_q == timer_ppg_pkg::MODE_STOP)[*3]
            |-> !match_a_irq && !match_b_irq)
        else $error("request while stopped");
    AST_GLITCH_REJECT: assert property (glitch_a |=> (!match_b_irq)[*4])
        else $error("short pulse captured");
    AST_CAPT_B_CAUSE: assert property (
        (fr && $stable(trigger_in_a))[*8] |-> !match_b_irq)
        else $error("capture b without an edge");
    AST_CAPT_A_CAUSE: assert property (
        (fr && $stable(trigger_in_b))[*8] |-> !match_a_irq)
        else $error("capture a without an edge");
endmodule // timer_ppg_props
bind timer_ppg_pulse_capture timer_ppg_props u_props (.ref_clk, .sys_rst,
    .ahb_req, .hreadyout, .hresp, .hrdata, .trigger_in_a, .trigger_in_b,
    .timer_out, .match_a_irq, .match_b_irq);
`default_nettype wire

// [test/pulse_pins.sv]
// pin-side model: two trigger sources
`timescale 1ns/1ps
`default_nettype none
module pulse_pins (
    // clock
    input wire logic ref_clk,
    // pins
    output logic trigger_in_a,
    output logic trigger_in_b
);
    initial begin
        trigger_in_a = 1'b0;
        trigger_in_b = 1'b0;
    end
    // set one pin just after an edge and hold it n cycles
    task automatic drive(input bit sel_b, input bit lvl, input int n);
        @(posedge ref_clk);
        if (sel_b) trigger_in_b <= lvl;
        else trigger_in_a <= lvl;
        repeat (n - 1) @(posedge ref_clk);
    endtask
endmodule // pulse_pins
`default_nettype wire

// [test/timer_ppg_pulse_capture_tb_top.sv]
// self-checking bench for the capture timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_ppg_map.svh"
module timer_ppg_pulse_capture_tb_top;
    localparam int DML = 2;
    localparam int DSL = 8;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    timer_ppg_pkg::ahb_req_t req = '0;
    timer_ppg_pkg::ahb_req_t bus;
    logic hreadyout, hresp, timer_out, match_a_irq, match_b_irq;
    logic trigger_in_a, trigger_in_b;
    logic [31:0] hrdata, rv;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int na = 0;
    int nb = 0;
    always #4 ref_clk = ~ref_clk;
    assign bus = {req[$bits(req)-1:1], hreadyout};
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        na <= na + (match_a_irq === 1'b1);
        nb <= nb + (match_b_irq === 1'b1);
        if (cyc == 90000) begin
            error_cnt++;
            end_sim();
        end
    end
    timer_ppg_pulse_capture #(.DIV_MID_LOG2(DML), .DIV_SLOW_LOG2(DSL))
    u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ahb_req(bus),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .trigger_in_a(trigger_in_a), .trigger_in_b(trigger_in_b),
        .timer_out(timer_out), .match_a_irq(match_a_irq),
        .match_b_irq(match_b_irq));
    pulse_pins u_pins (.ref_clk(ref_clk), .trigger_in_a(trigger_in_a),
        .trigger_in_b(trigger_in_b));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single word transfer; read data lands in rv
    task automatic xfer(input bit wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        req.hsel <= 1'b1;
        req.haddr <= {20'h00000, a};
        req.htrans <= 2'h2;
        req.hwrite <= wr;
        req.hsize <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic irq_gap(output int n);
        n = 0;
        @(posedge ref_clk iff match_a_irq === 1'b1);
        do begin
            @(posedge ref_clk);
            n++;
        end while (match_a_irq !== 1'b1);
    endtask
    task automatic meas(output int hi, output int lo);
        @(posedge ref_clk iff timer_out === 1'b0);
        @(posedge ref_clk iff timer_out === 1'b1);
        hi = 0;
        lo = 0;
        while (timer_out === 1'b1) begin
            @(posedge ref_clk);
            hi++;
        end
        while (timer_out === 1'b0) begin
            @(posedge ref_clk);
            lo++;
        end
    endtask
    task automatic t_interval;
        int n;
        int sel[4] = '{0, 0, 1, 2};
        int per[4] = '{1, 3, 3, 1};
        int sh[4] = '{0, 0, DML, DSL};
        for (int i = 0; i < 4; i++) begin
            xfer(1, `OFS_TIMER_MODE_CTRL, 0);
            xfer(1, `OFS_CAPCOMP_CTRL, 0);
            xfer(1, `OFS_COMPARE_CAPTURE_A, per[i]);
            xfer(1, `OFS_PRESCALER_MODE, sel[i]);
            xfer(1, `OFS_TIMER_MODE_CTRL, 1);
            irq_gap(n);
            chk(n, (per[i] + 1) << sh[i]);
        end
        // count clock from filtered trigger_in_a edges, period a + 1 = 2
        xfer(1, `OFS_TIMER_MODE_CTRL, 0);
        xfer(1, `OFS_PRESCALER_MODE, 32'h33);
        xfer(1, `OFS_TIMER_MODE_CTRL, 1);
        n = na;
        repeat (2) begin
            u_pins.drive(0, 1, 4);
            u_pins.drive(0, 0, 8);
        end
        chk(na - n, 2);
        xfer(0, `OFS_STATUS, 0);
        chk(rv, 0);
        $display("interval test done");
    endtask
    task automatic t_ppg;
        int hi, lo;
        xfer(1, `OFS_TIMER_MODE_CTRL, 0);
        xfer(1, `OFS_CAPCOMP_CTRL, 0);
        xfer(1, `OFS_COMPARE_CAPTURE_A, 39);
        xfer(1, `OFS_COMPARE_CAPTURE_B, 19);
        xfer(1, `OFS_OUTPUT_CTRL, 32'h13);
        xfer(1, `OFS_PRESCALER_MODE, 0);
        xfer(1, `OFS_TIMER_MODE_CTRL, 2);
        meas(hi, lo);
        chk(hi, 20);
        chk(hi + lo, 40);
        @(posedge ref_clk iff match_a_irq === 1'b1);
        xfer(1, `OFS_OUTPUT_CTRL, 32'h03);
        xfer(1, `OFS_COMPARE_CAPTURE_B, 29);
        @(posedge ref_clk);
        xfer(1, `OFS_OUTPUT_CTRL, 32'h13);
        meas(hi, lo);
        chk(hi, 30);
        xfer(1, `OFS_OUTPUT_CTRL, 32'h03);
        meas(hi, lo);
        chk(hi, 40);
        $display("pulse test done");
    endtask
    task automatic t_fr_one;
        int x[4] = '{1, 1, 0, 2};
        int n0;
        logic [31:0] c0;
        for (int i = 0; i < 4; i++) begin
            xfer(1, `OFS_TIMER_MODE_CTRL, 0);
            xfer(1, `OFS_CAPCOMP_CTRL, 0);
            xfer(1, `OFS_PRESCALER_MODE, i << 4);
            xfer(1, `OFS_TIMER_MODE_CTRL, 3);
            n0 = nb;
            // high 20 cycles: 17 here and 3 in the read
            u_pins.drive(0, 1, 17);
            xfer(0, `OFS_COMPARE_CAPTURE_B, 0);
            c0 = rv;
            u_pins.drive(0, 0, 20);
            xfer(0, `OFS_COMPARE_CAPTURE_B, 0);
            if (i == 3) chk(rv - c0, 20);
            u_pins.drive(0, 1, 1);
            u_pins.drive(0, 0, 10);
            chk(nb - n0, x[i]);
        end
        $display("one capture test done");
    endtask
    task automatic t_fr_two;
        int n0;
        logic [31:0] c0;
        xfer(1, `OFS_TIMER_MODE_CTRL, 0);
        xfer(1, `OFS_CAPCOMP_CTRL, 1);
        xfer(1, `OFS_PRESCALER_MODE, 32'hF0);
        xfer(1, `OFS_TIMER_MODE_CTRL, 3);
        n0 = na;
        // high 12 cycles: 9 here and 3 in the read
        u_pins.drive(1, 1, 9);
        xfer(0, `OFS_COMPARE_CAPTURE_A, 0);
        c0 = rv;
        u_pins.drive(1, 0, 12);
        xfer(0, `OFS_COMPARE_CAPTURE_A, 0);
        chk(rv - c0, 12);
        chk(na - n0, 2);
        xfer(0, `OFS_STATUS, 0);
        chk(rv, 0);
        repeat (65536) @(posedge ref_clk);
        xfer(0, `OFS_STATUS, 0);
        chk(rv, 1);
        xfer(1, `OFS_STATUS, 1);
        xfer(0, `OFS_STATUS, 0);
        chk(rv, 0);
        $display("two capture test done");
    endtask
    task automatic t_reset;
        // reset values, the last offset unmapped
        for (int o = 0; o < 36; o += 4) begin
            xfer(0, o[11:0], 0);
            chk(rv, 0);
        end
        xfer(1, 12'h020, 32'hFFFFFFFF);
        xfer(0, 12'h020, 0);
        chk(rv, 0);
        $display("reset test done");
    endtask
    task automatic end_sim;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_interval();
        t_ppg();
        t_fr_one();
        t_fr_two();
        end_sim();
    end
endmodule // timer_ppg_pulse_capture_tb_top
`default_nettype wire
